/* standby_ctrl_map.vh */
`ifndef STANDBY_CTRL_MAP_VH
`define STANDBY_CTRL_MAP_VH

// register word offsets
`define REG_CTRL          4'h0
`define REG_STAB_SEL      4'h1
`define REG_STATUS        4'h2
`define REG_PERIPH        4'h3

// control register fields
`define CTRL_HS_DIS       0
`define CTRL_CLK_SRC      1
`define CTRL_AMP_HIGH     3
`define CTRL_WDT_SW_STOP  4
`define CTRL_LS_DIS       5
`define CTRL_X1_ON        6
`define CTRL_RESET        32'h0000_0000

// stabilization wait select
`define STAB_SEL_W        3
`define STAB_SEL_RST      3'h5
`define STAB_11           3'h1
`define STAB_13           3'h2
`define STAB_14           3'h3
`define STAB_15           3'h4
`define STAB_16           3'h5
`define STAB_CNT_W        17
`define STAB_STATUS_W     5

// cpu clock source codes
`define SRC_INT_HS        2'h0
`define SRC_X1            2'h1
`define SRC_EXT           2'h2
`define SRC_SUB           2'h3

// periph clock select fields
`define PS_CNTA_EXT       0
`define PS_CNTB_EXT       1
`define PS_IT1_TMA        2
`define PS_IT2_LS         3
`define PS_RTC_SUB        4
`define PS_CKO_SUB        5
`define PS_UART_TMA       6
`define PS_CSI_EXT        7
`define PS_PRS_RUN        8
`define PS_W              9

// release waits, in cpu clocks (upper figure of each pair)
`define WAIT_HALT_VEC     8'd12
`define WAIT_HALT_NOVEC   8'd5
`define WAIT_STOP_VEC     8'd18
`define WAIT_STOP_NOVEC   8'd12

// high-amplitude hold after stop
`define AMP_INT_CLKS      12'h0FBE
`define AMP_EXT_CLKS      8'd160

`endif

/* standby_halt_stop_control.v */
`timescale 1ns/1ns
`include "standby_ctrl_map.vh"
// Summary of operation
// RULE1: halt instruction enters halt from any cpu clock source.
// RULE2: halt gates cpu clock; memories and port latches keep contents.
// RULE3: clock feeding cpu keeps running in halt; others keep state.
// RULE4: halt from subsystem clock: timer needs peripheral clock, converter, amplifier off.
// RULE5: watchdog runs in standby unless option lets software stop low-speed oscillator.
// RULE6: unmasked interrupt ends halt; vectored if enabled else next instruction.
// RULE7: halt release waits 12 clocks vectored, 5 clocks not vectored.
// RULE8: reset during halt ends it like a normal reset.
// RULE9: mask, priority, enable and in-service decide hold, service or fall-through.
// RULE10: stop entered only from main system clock, not subsystem.
// RULE11: pending unmasked interrupt at stop drops to halt, waits stabilization.
// RULE12: stop halts internal and crystal clocks, ignores external clock.
// RULE13: stop halts timer, converter, multiplier; counters run only on own pins.
// RULE14: stop: first interval timer on counter a output, second on low-speed clock.
// RULE15: stop: real-time counter and clock output run only on subsystem clock.
// RULE16: stop: async on counter output, sync on external clock, two-wire wakeup.
// RULE17: stop never halts low-speed oscillator; software disables it beforehand.
// RULE18: high amplitude option withholds cpu clock 16.12 us or 160 external clocks.
// RULE19: software issues stop only when internal oscillator stable flag is one.
// RULE20: software switches to internal oscillator before stop to shorten wakeup.
// RULE21: software checks stabilization status before returning to crystal clock.
// RULE22: software restarts stopped peripherals and avoids pin clocks in stop.
// RULE23: wait select codes 1..5 pick 2^11..2^16 crystal cycles; reset picks longest.
// RULE24: stop release waits 18 clocks vectored, 12 clocks not vectored.
// RULE25: one registered mode state run, halt or stop; reset forces run.
module standby_halt_stop_control (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        rst_i,
    // avalon-mm slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // cpu core
    input  wire        halt_instr_i,
    input  wire        stop_instr_i,
    output reg         cpu_clk_en_o,
    output reg         vector_req_o,
    output reg         resume_o,
    // interrupt controller flags
    input  wire        irq_req_i,
    input  wire        irq_mask_flag_i,
    input  wire        irq_priority_flag_i,
    input  wire        global_irq_enable_i,
    input  wire        in_service_priority_flag_i,
    // clock ticks from pins and oscillators
    input  wire        crystal_clk_i,
    input  wire        ext_main_clk_i,
    input  wire        two_wire_addr_match_i,
    // oscillator enables
    output reg         int_hs_osc_en_o,
    output reg         x1_osc_en_o,
    output reg         ext_clk_in_en_o,
    output reg         low_speed_osc_en_o,
    output reg         wdt_clk_en_o,
    // peripheral run enables
    output reg         timer16_en_o,
    output reg         counter_a_en_o,
    output reg         counter_b_en_o,
    output reg         interval_timer_first_en_o,
    output reg         interval_timer_second_en_o,
    output reg         rtc_en_o,
    output reg         clk_out_en_o,
    output reg         adc_en_o,
    output reg         amp_en_o,
    output reg         async_serial_unit_en_o,
    output reg         sync_serial_unit_en_o,
    output reg         two_wire_serial_unit_en_o,
    output reg         muldiv_en_o,
    output reg         wakeup_o,
    // mode indicator
    output reg  [1:0]  mode_o
);

    localparam [1:0] M_RUN  = 2'd0;
    localparam [1:0] M_HALT = 2'd1;
    localparam [1:0] M_STOP = 2'd2;

    localparam [2:0] S_RUN  = 3'd0;
    localparam [2:0] S_HALT = 3'd1;
    localparam [2:0] S_STOP = 3'd2;
    localparam [2:0] S_STAB = 3'd3;
    localparam [2:0] S_AMP  = 3'd4;
    localparam [2:0] S_WAIT = 3'd5;

    // pin-side ticks pass two flip-flops before use
    reg [1:0] xt_sync_r;
    reg [1:0] ext_sync_r;
    reg [1:0] wk_sync_r;
    reg       xt_prev_r;
    reg       ext_prev_r;

    reg [31:0] ctrl_r;
    reg [`STAB_SEL_W-1:0] stab_sel_r;
    reg [`PS_W-1:0] psel_r;
    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [`STAB_CNT_W-1:0] stab_cnt_r;
    reg [11:0] amp_cnt_r;
    reg [7:0]  wait_cnt_r;
    reg        vec_r;
    reg        rd_pend_r;
    reg        wr_pend_r;

    wire [1:0] src = ctrl_r[`CTRL_CLK_SRC+1:`CTRL_CLK_SRC];
    wire xt_tick  = xt_sync_r[1] & ~xt_prev_r;
    wire ext_tick = ext_sync_r[1] & ~ext_prev_r;

    // maskable release decision
    wire unmasked = irq_req_i & ~irq_mask_flag_i; // RULE9
    wire vec_now  = irq_priority_flag_i ? (global_irq_enable_i & in_service_priority_flag_i)
                                        : global_irq_enable_i; // RULE9

    function [`STAB_CNT_W-1:0] stab_limit;
        input [`STAB_SEL_W-1:0] sel;
        begin
            if (sel == `STAB_11)
                stab_limit = 17'h0_0800; // RULE23
            else if (sel == `STAB_13)
                stab_limit = 17'h0_2000;
            else if (sel == `STAB_14)
                stab_limit = 17'h0_4000;
            else if (sel == `STAB_15)
                stab_limit = 17'h0_8000;
            else
                stab_limit = 17'h1_0000;
        end
    endfunction

    function [`STAB_STATUS_W-1:0] stab_status;
        input [`STAB_CNT_W-1:0] cnt;
        begin
            stab_status = {cnt >= 17'h0_0800, cnt >= 17'h0_2000, cnt >= 17'h0_4000,
                           cnt >= 17'h0_8000, cnt >= 17'h1_0000};
        end
    endfunction

    // state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_RUN: begin
                if (stop_instr_i && src != `SRC_SUB) begin // RULE10
                    if (unmasked)
                        state_nxt = S_STAB; // RULE11
                    else
                        state_nxt = S_STOP;
                end else if (halt_instr_i) begin
                    state_nxt = S_HALT; // RULE1
                end
            end
            S_HALT: begin
                if (unmasked)
                    state_nxt = S_WAIT; // RULE6
            end
            S_STOP: begin
                if (unmasked)
                    state_nxt = S_STAB;
            end
            S_STAB: begin
                if (src != `SRC_X1)
                    state_nxt = ctrl_r[`CTRL_AMP_HIGH] ? S_AMP : S_WAIT;
                else if (stab_cnt_r >= stab_limit(stab_sel_r))
                    state_nxt = S_WAIT;
            end
            S_AMP: begin
                if (amp_cnt_r == 12'h000)
                    state_nxt = S_WAIT; // RULE18
            end
            S_WAIT: begin
                if (wait_cnt_r == 8'h00)
                    state_nxt = S_RUN;
            end
            default: state_nxt = S_RUN;
        endcase
    end

    // reset anywhere returns to run, like a normal reset
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r     <= S_RUN; // RULE8
            xt_sync_r   <= 2'b00;
            ext_sync_r  <= 2'b00;
            wk_sync_r   <= 2'b00;
            xt_prev_r   <= 1'b0;
            ext_prev_r  <= 1'b0;
            stab_cnt_r  <= {`STAB_CNT_W{1'b0}};
            amp_cnt_r   <= 12'h000;
            wait_cnt_r  <= 8'h00;
            vec_r       <= 1'b0;
        end else begin
            xt_sync_r   <= {xt_sync_r[0], crystal_clk_i};
            ext_sync_r  <= {ext_sync_r[0], ext_main_clk_i};
            wk_sync_r   <= {wk_sync_r[0], two_wire_addr_match_i};
            xt_prev_r   <= xt_sync_r[1];
            ext_prev_r  <= ext_sync_r[1];
            state_r     <= state_nxt;
            if (state_r == S_RUN && state_nxt != S_RUN)
                stab_cnt_r <= {`STAB_CNT_W{1'b0}};
            else if (state_r == S_STAB && xt_tick && stab_cnt_r != {`STAB_CNT_W{1'b1}})
                stab_cnt_r <= stab_cnt_r + 1'b1;
            if (state_r == S_STAB) begin
                if (src == `SRC_EXT)
                    amp_cnt_r <= {4'h0, `AMP_EXT_CLKS};
                else
                    amp_cnt_r <= `AMP_INT_CLKS;
            end else if (state_r == S_AMP && amp_cnt_r != 12'h000) begin
                if (src != `SRC_EXT || ext_tick)
                    amp_cnt_r <= amp_cnt_r - 1'b1;
            end
            if (state_nxt == S_WAIT && state_r != S_WAIT) begin
                vec_r <= vec_now;
                if (state_r != S_HALT)
                    wait_cnt_r <= vec_now ? `WAIT_STOP_VEC : `WAIT_STOP_NOVEC; // RULE24
                else
                    wait_cnt_r <= vec_now ? `WAIT_HALT_VEC : `WAIT_HALT_NOVEC; // RULE7
            end else if (state_r == S_WAIT && wait_cnt_r != 8'h00) begin
                wait_cnt_r <= wait_cnt_r - 1'b1;
            end
        end
    end

    // outputs, all registered
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_o                     <= M_RUN; // RULE25
            cpu_clk_en_o               <= 1'b1;
            vector_req_o               <= 1'b0;
            resume_o                   <= 1'b0;
            int_hs_osc_en_o            <= 1'b1;
            x1_osc_en_o                <= 1'b0;
            ext_clk_in_en_o            <= 1'b0;
            low_speed_osc_en_o         <= 1'b1;
            wdt_clk_en_o               <= 1'b1;
            timer16_en_o               <= 1'b1;
            counter_a_en_o             <= 1'b1;
            counter_b_en_o             <= 1'b1;
            interval_timer_first_en_o  <= 1'b1;
            interval_timer_second_en_o <= 1'b1;
            rtc_en_o                   <= 1'b1;
            clk_out_en_o               <= 1'b1;
            adc_en_o                   <= 1'b1;
            amp_en_o                   <= 1'b1;
            async_serial_unit_en_o     <= 1'b1;
            sync_serial_unit_en_o      <= 1'b1;
            two_wire_serial_unit_en_o  <= 1'b1;
            muldiv_en_o                <= 1'b1;
            wakeup_o                   <= 1'b0;
        end else begin
            mode_o <= (state_nxt == S_STOP) ? M_STOP : (state_nxt == S_RUN) ? M_RUN : M_HALT; // RULE25
            cpu_clk_en_o <= (state_nxt == S_RUN); // RULE2
            vector_req_o <= (state_r == S_WAIT && state_nxt == S_RUN && vec_r); // RULE6
            resume_o     <= (state_r == S_WAIT && state_nxt == S_RUN && !vec_r);
            // source in use kept running outside stop, stop turns both off; others follow software state
            int_hs_osc_en_o <= (state_nxt == S_STOP) ? 1'b0 :
                               (~ctrl_r[`CTRL_HS_DIS] | (src == `SRC_INT_HS)); // RULE3 RULE12
            x1_osc_en_o     <= (state_nxt == S_STOP) ? 1'b0 :
                               (ctrl_r[`CTRL_X1_ON] | (src == `SRC_X1)); // RULE3 RULE12
            ext_clk_in_en_o <= (state_nxt != S_STOP); // RULE12
            low_speed_osc_en_o <= ~(ctrl_r[`CTRL_WDT_SW_STOP] & ctrl_r[`CTRL_LS_DIS]); // RULE17
            wdt_clk_en_o <= ~((state_nxt != S_RUN) & ctrl_r[`CTRL_WDT_SW_STOP]); // RULE5
            if (state_nxt == S_STOP) begin
                timer16_en_o               <= 1'b0; // RULE13
                counter_a_en_o             <= psel_r[`PS_CNTA_EXT];
                counter_b_en_o             <= psel_r[`PS_CNTB_EXT];
                interval_timer_first_en_o  <= psel_r[`PS_IT1_TMA] & psel_r[`PS_CNTA_EXT]; // RULE14
                interval_timer_second_en_o <= psel_r[`PS_IT2_LS]; // RULE14
                rtc_en_o                   <= psel_r[`PS_RTC_SUB]; // RULE15
                clk_out_en_o               <= psel_r[`PS_CKO_SUB]; // RULE15
                adc_en_o                   <= 1'b0;
                amp_en_o                   <= 1'b1;
                async_serial_unit_en_o     <= psel_r[`PS_UART_TMA] & psel_r[`PS_CNTA_EXT]; // RULE16
                sync_serial_unit_en_o      <= psel_r[`PS_CSI_EXT]; // RULE16
                two_wire_serial_unit_en_o  <= 1'b1; // RULE16
                muldiv_en_o                <= 1'b0; // RULE13
            end else begin
                // halt on subsystem clock shuts the analog side
                timer16_en_o <= ~(state_nxt == S_HALT && src == `SRC_SUB && !psel_r[`PS_PRS_RUN]); // RULE4
                adc_en_o     <= ~(state_nxt == S_HALT && src == `SRC_SUB); // RULE4
                amp_en_o     <= ~(state_nxt == S_HALT && src == `SRC_SUB); // RULE4
                counter_a_en_o             <= 1'b1;
                counter_b_en_o             <= 1'b1;
                interval_timer_first_en_o  <= 1'b1;
                interval_timer_second_en_o <= 1'b1;
                rtc_en_o                   <= 1'b1;
                clk_out_en_o               <= 1'b1;
                async_serial_unit_en_o     <= 1'b1;
                sync_serial_unit_en_o      <= 1'b1;
                two_wire_serial_unit_en_o  <= 1'b1;
                muldiv_en_o                <= 1'b1;
            end
            wakeup_o <= (state_r == S_STOP) & wk_sync_r[1]; // RULE16
        end
    end

    // avalon slave: one wait cycle; writes land on the answering edge
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r            <= `CTRL_RESET;
            stab_sel_r        <= `STAB_SEL_RST; // RULE23
            psel_r            <= {`PS_W{1'b0}};
            rd_pend_r         <= 1'b0;
            wr_pend_r         <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else begin
            rd_pend_r         <= avs_read_i & ~rd_pend_r;
            wr_pend_r         <= avs_write_i & ~wr_pend_r;
            avs_waitrequest_o <= ~((avs_read_i & ~rd_pend_r) | (avs_write_i & ~wr_pend_r));
            if (avs_write_i && wr_pend_r) begin
                if (avs_address_i == `REG_CTRL && avs_byteenable_i[0])
                    ctrl_r[7:0] <= avs_writedata_i[7:0];
                else if (avs_address_i == `REG_STAB_SEL && avs_byteenable_i[0]) begin
                    if (avs_writedata_i[2:0] >= `STAB_11 && avs_writedata_i[2:0] <= `STAB_16)
                        stab_sel_r <= avs_writedata_i[`STAB_SEL_W-1:0]; // RULE23
                end else if (avs_address_i == `REG_PERIPH) begin
                    if (avs_byteenable_i[0])
                        psel_r[7:0] <= avs_writedata_i[7:0];
                    if (avs_byteenable_i[1])
                        psel_r[8] <= avs_writedata_i[8];
                end
            end
            if (avs_read_i && !rd_pend_r) begin
                if (avs_address_i == `REG_CTRL)
                    avs_readdata_o <= ctrl_r;
                else if (avs_address_i == `REG_STAB_SEL)
                    avs_readdata_o <= {29'h0, stab_sel_r};
                else if (avs_address_i == `REG_STATUS)
                    avs_readdata_o <= {24'h0, state_r, stab_status(stab_cnt_r)}; // RULE21
                else if (avs_address_i == `REG_PERIPH)
                    avs_readdata_o <= {23'h0, psel_r};
                else
                    avs_readdata_o <= 32'h0000_0000;
            end
        end
    end

endmodule // standby_halt_stop_control

/* standby_chk.sv */
`timescale 1ns/1ns
module standby_chk (
    // clock and reset
    input wire       core_clk_i,
    input wire       rst_i,
    // cpu side
    input wire       halt_instr_i,
    input wire       stop_instr_i,
    input wire       cpu_clk_en_o,
    input wire       vector_req_o,
    input wire       resume_o,
    // interrupt flags
    input wire       irq_req_i,
    input wire       irq_mask_flag_i,
    input wire       irq_priority_flag_i,
    input wire       global_irq_enable_i,
    input wire       in_service_priority_flag_i,
    // gating outputs
    input wire       int_hs_osc_en_o,
    input wire       x1_osc_en_o,
    input wire       timer16_en_o,
    input wire       adc_en_o,
    input wire [1:0] mode_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire vec_ok = global_irq_enable_i && (!irq_priority_flag_i || in_service_priority_flag_i);
    wire irq_up = irq_req_i && !irq_mask_flag_i;
    property p_halt_entry;
        halt_instr_i && mode_o == 2'h0 && !irq_up |=> mode_o == 2'h1 && !cpu_clk_en_o;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");
    property p_halt_gate;
        mode_o == 2'h1 && irq_mask_flag_i |-> !cpu_clk_en_o;
    endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("cpu clocked in halt");
    property p_stop_clocks;
        mode_o == 2'h2 |-> !cpu_clk_en_o && !int_hs_osc_en_o && !x1_osc_en_o;
    endproperty
    a_stop_clocks: assert property (p_stop_clocks) else $error("clock running in stop");
    property p_stop_periph;
        mode_o == 2'h2 |-> !timer16_en_o && !adc_en_o;
    endproperty
    a_stop_periph: assert property (p_stop_periph) else $error("peripheral running in stop");
    // flags stand until the release pulse
    property p_vec_cause;
        vector_req_o |-> vec_ok;
    endproperty
    a_vec_cause: assert property (p_vec_cause) else $error("vectored without enable");
    property p_resume_cause;
        resume_o |-> !vec_ok;
    endproperty
    a_resume_cause: assert property (p_resume_cause) else $error("fall-through while enabled");
    property p_halt_vec_wait;
        mode_o == 2'h1 && irq_up && !$past(irq_up) && vec_ok |-> ##[11:16] vector_req_o;
    endproperty
    a_halt_vec_wait: assert property (p_halt_vec_wait) else $error("vectored release late");
    property p_halt_novec_wait;
        mode_o == 2'h1 && irq_up && !$past(irq_up) && !vec_ok |-> ##[4:8] resume_o;
    endproperty
    a_halt_novec_wait: assert property (p_halt_novec_wait) else $error("plain release late");
    property p_stop_pending;
        stop_instr_i && mode_o == 2'h0 && irq_up |=> mode_o == 2'h1;
    endproperty
    a_stop_pending: assert property (p_stop_pending) else $error("stop not dropped to halt");
    property p_reset_run;
        $fell(rst_i) |-> mode_o == 2'h0 && cpu_clk_en_o;
    endproperty
    a_reset_run: assert property (p_reset_run) else $error("not running after reset");
    property p_mode_legal;
        mode_o != 2'h3;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");
endmodule // standby_chk

bind standby_halt_stop_control standby_chk u_chk (.core_clk_i, .rst_i, .halt_instr_i, .stop_instr_i,
    .cpu_clk_en_o, .vector_req_o, .resume_o, .irq_req_i, .irq_mask_flag_i, .irq_priority_flag_i,
    .global_irq_enable_i, .in_service_priority_flag_i, .int_hs_osc_en_o, .x1_osc_en_o,
    .timer16_en_o, .adc_en_o, .mode_o);

/* cpu_irq_model.sv */
`timescale 1ns/1ns
module cpu_irq_model (
    // clock and reset
    input  wire       core_clk_i,
    input  wire       rst_i,
    // bench commands
    input  wire       cmd_halt_i,
    input  wire       cmd_stop_i,
    input  wire       raise_i,
    input  wire       clear_i,
    input  wire [3:0] cfg_i,
    // from the controller
    input  wire       cpu_clk_en_i,
    input  wire       int_hs_osc_en_i,
    input  wire       vector_req_i,
    // to the controller
    output reg        halt_instr_o,
    output reg        stop_instr_o,
    output reg        irq_req_o,
    output reg  [3:0] flags_o
);
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {halt_instr_o, stop_instr_o, irq_req_o} <= 3'h0;
            flags_o <= 4'h8;
        end else begin
            // a gated cpu executes nothing
            halt_instr_o <= cmd_halt_i && cpu_clk_en_i;
            stop_instr_o <= cmd_stop_i && cpu_clk_en_i && int_hs_osc_en_i;
            flags_o <= cfg_i;
            // vectored service acknowledges the request
            if (vector_req_i || clear_i) begin
                irq_req_o <= 1'b0;
            end else if (raise_i) begin
                irq_req_o <= 1'b1;
            end
        end
    end
endmodule // cpu_irq_model

/* standby_halt_stop_control_tb_top.sv */
`timescale 1ns/1ns
module standby_halt_stop_control_tb_top;
    logic        core_clk_i, rst_i, avs_read_i, avs_write_i, cmd_halt, cmd_stop, raise, clear;
    logic [3:0]  avs_address_i, cfg, flags;
    logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
    logic        avs_waitrequest_o, halt_instr_i, stop_instr_i, cpu_clk_en_o, vector_req_o, resume_o;
    logic        irq_req_i, int_hs_osc_en_o, x1_osc_en_o, ext_clk_in_en_o, low_speed_osc_en_o;
    logic        wdt_clk_en_o, timer16_en_o, adc_en_o, amp_en_o, muldiv_en_o;
    logic [1:0]  mode_o;
    logic [4:0]  tbl [6] = '{5'h00, 5'h12, 5'h13, 5'h05, 5'h06, 5'h17};
    int          failures, tests_run;

    standby_halt_stop_control dut (.core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .halt_instr_i,
        .stop_instr_i, .cpu_clk_en_o, .vector_req_o, .resume_o, .irq_req_i, .irq_mask_flag_i(flags[3]),
        .irq_priority_flag_i(flags[2]), .global_irq_enable_i(flags[1]), .in_service_priority_flag_i(flags[0]),
        .crystal_clk_i(1'b0), .ext_main_clk_i(1'b0), .two_wire_addr_match_i(1'b0), .int_hs_osc_en_o,
        .x1_osc_en_o, .ext_clk_in_en_o, .low_speed_osc_en_o, .wdt_clk_en_o, .timer16_en_o,
        .counter_a_en_o(), .counter_b_en_o(), .interval_timer_first_en_o(), .interval_timer_second_en_o(),
        .rtc_en_o(), .clk_out_en_o(), .adc_en_o, .amp_en_o, .async_serial_unit_en_o(),
        .sync_serial_unit_en_o(), .two_wire_serial_unit_en_o(), .muldiv_en_o, .wakeup_o(), .mode_o);
    cpu_irq_model cpu (.core_clk_i, .rst_i, .cmd_halt_i(cmd_halt), .cmd_stop_i(cmd_stop), .raise_i(raise),
        .clear_i(clear), .cfg_i(cfg), .cpu_clk_en_i(cpu_clk_en_o), .int_hs_osc_en_i(int_hs_osc_en_o),
        .vector_req_i(vector_req_o), .halt_instr_o(halt_instr_i), .stop_instr_o(stop_instr_i),
        .irq_req_o(irq_req_i), .flags_o(flags));

    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    task end_sim;
        $display("failures %0d checks %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk_i);
        {avs_address_i, avs_writedata_i, avs_write_i, avs_read_i} <= {a, d, wr, !wr};
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (i == 50) begin
            failures++;
            end_sim;
        end
        rdv = avs_readdata_o;
        {avs_write_i, avs_read_i} <= 2'h0;
    endtask

    // k: 0 halt, 1 stop, 2 raise, 3 clear
    task strobe(input int k);
        @(posedge core_clk_i);
        {cmd_halt, cmd_stop, raise, clear} <= 4'h8 >> k;
        @(posedge core_clk_i);
        {cmd_halt, cmd_stop, raise, clear} <= 4'h0;
        repeat (3) @(posedge core_clk_i);
    endtask

    task wait_rel(output int n, output logic v);
        n = 0;
        while (vector_req_o !== 1'b1 && resume_o !== 1'b1) begin
            @(posedge core_clk_i);
            n++;
            if (n > 6000) begin
                failures++;
                end_sim;
            end
        end
        v = vector_req_o;
    endtask

    task t_regs;
        chk("reset mode", mode_o, 2'h0);
        chk("reset cpu clock", cpu_clk_en_o, 1'b1);
        bus(1'b0, 4'h1, 32'h0000_0000);
        chk("wait select reset", rdv[2:0], 3'h5);
        bus(1'b1, 4'h1, 32'h0000_0001);
        bus(1'b1, 4'h1, 32'h0000_0007);
        bus(1'b1, 4'h9, 32'h0000_0003);
        bus(1'b0, 4'h1, 32'h0000_0000);
        chk("wait select code", rdv[2:0], 3'h1);
        bus(1'b0, 4'h9, 32'h0000_0000);
        chk("unmapped read", rdv, 32'h0000_0000);
    endtask

    // masked request holds halt until unmasked
    task t_halt(input logic [3:0] c, input logic ev);
        int n;
        logic v;
        cfg <= 4'h8 | c;
        strobe(0);
        chk("halt mode", mode_o, 2'h1);
        chk("halt cpu clock", cpu_clk_en_o, 1'b0);
        chk("halt osc", int_hs_osc_en_o, 1'b1);
        chk("halt watchdog", wdt_clk_en_o, 1'b1);
        strobe(2);
        repeat (20) @(posedge core_clk_i);
        chk("masked hold", mode_o, 2'h1);
        cfg <= c;
        wait_rel(n, v);
        chk("vectored", v, ev);
        chk("halt wait", ev ? (n >= 11 && n <= 18) : (n >= 4 && n <= 10), 1'b1);
        strobe(3);
    endtask

    task t_stop;
        int n;
        logic v;
        bus(1'b1, 4'h0, 32'h0000_0008);
        cfg <= 4'h2;
        strobe(1);
        chk("stop mode", mode_o, 2'h2);
        chk("stop hs osc", int_hs_osc_en_o, 1'b0);
        chk("stop ext clk", ext_clk_in_en_o, 1'b0);
        chk("stop low speed", low_speed_osc_en_o, 1'b1);
        chk("stop muldiv", muldiv_en_o, 1'b0);
        strobe(2);
        wait_rel(n, v);
        chk("stop vectored", v, 1'b1);
        chk("amp hold", n >= 1028 && n <= 4060, 1'b1);
        bus(1'b1, 4'h0, 32'h0000_0000);
        cfg <= 4'h0;
        strobe(2);
        strobe(1);
        chk("stop pending", mode_o, 2'h1);
        wait_rel(n, v);
        chk("pending plain", v, 1'b0);
        chk("pending wait", n >= 11 && n <= 16, 1'b1);
        strobe(3);
    endtask

    task t_sub;
        bus(1'b1, 4'h0, 32'h0000_0006);
        cfg <= 4'h8;
        strobe(1);
        chk("no stop from sub", mode_o, 2'h0);
        strobe(0);
        chk("sub halt adc", adc_en_o, 1'b0);
        chk("sub halt amp", amp_en_o, 1'b0);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        chk("reset from halt", mode_o, 2'h0);
        chk("reset cpu clock", cpu_clk_en_o, 1'b1);
    endtask

    initial begin
        failures = 0;
        tests_run = 0;
        {rst_i, avs_read_i, avs_write_i, cmd_halt, cmd_stop, raise, clear} = 7'h40;
        {avs_address_i, avs_writedata_i, cfg} = {4'h0, 32'h0000_0000, 4'h8};
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_regs;
        foreach (tbl[i]) t_halt(tbl[i][3:0], tbl[i][4]);
        t_stop;
        t_sub;
        end_sim;
    end
endmodule // standby_halt_stop_control_tb_top
